// ### logic/rpp_top.v
// Operation
// (R1) Fast peak trip kills drive immediately
// (R2) Calculated peak above 16 percent trips
// (R3) Five trip sources share one shutback
// (R4) Hold zero power 100 ms
// (R5) Exponential ramp to lower target
// (R6) After 30 s return to loop
// (R7) Each shutback sets accumulator to one; code adds one per shutback and restarts at one only on a cutback
// (R8) Accumulator decays to zero in 60 s
// (R9) Cutback when accumulator exceeds threshold
// (R10) First cutback: 85 percent of lower
// (R11) Further cutbacks scale limit by 85 percent
// (R12) Limit never below 25 percent floor
// (R13) Restore only after accumulator reaches zero
// (R14) 5 s average above 4 percent folds back; code uses a single-pole average with a 4096 ms time constant
// (R15) Drive inhibit hold during faults
// (R16) Threshold and restore slope configurable
// (R17) Timers from millisecond prescaler tick
`timescale 1ns/1ps
`include "rpp_defines.vh"
module rpp_top #(
    parameter [15:0] ACC_THR   = `RPP_ACC_THR,
    parameter [15:0] REST_STEP = 16'h0001,
    parameter        TICK_DIV  = `RPP_TICK_CYC
) (
    // Clock and reset
    input  wire        hclk,
    input  wire        hresetn,
    // AHB-Lite slave
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output wire [31:0] hrdata,
    output wire        hreadyout,
    output wire        hresp,
    // Reflected power samples (fraction of rated, 1/4096)
    input  wire [15:0] calc_peak_reflect,
    input  wire [15:0] avg_reflect_sample,
    input  wire        sample_valid,
    // Trip pins: fast, over-current, over-voltage, arc
    input  wire [3:0]  trip_pins,
    // Power stage
    output wire        fast_reflect_trip_alarm,
    output reg         calc_reflect_trip_alarm,
    output wire        drive_disable,
    output wire        modulation_zero,
    output reg         drive_inhibit_hold,
    output reg  [15:0] power_limit,
    output reg         output_level_loop,
    // Interrupt
    output wire        irq
);
    // ------------------------------------------------------------
    // Trip inputs
    // ------------------------------------------------------------
    wire [3:0] trips_sync;   // Filtered copies for sequencing
    wire       tick_ms;      // Millisecond enable

    rpp_sync #(.W(4)) u_sync (
        .hclk    (hclk),
        .hresetn (hresetn),
        .pin     (trip_pins),
        .clean   (trips_sync)
    );
    rpp_tick #(.DIV(TICK_DIV)) u_tick (
        .hclk    (hclk),
        .hresetn (hresetn),
        .tick_ms (tick_ms)
    );

    // Fast path bypasses sync: 100 ns is only ten cycles
    assign fast_reflect_trip_alarm = trip_pins[0];                 // (R1)
    reg    fast_latch;                                              // Held kill after pulse
    assign drive_disable   = trip_pins[0] | fast_latch | drive_inhibit_hold; // (R1)
    assign modulation_zero = trip_pins[0] | fast_latch;             // (R1)

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    reg  [31:0] ctrl;        // Bit 0 enable
    reg  [15:0] setpoint;    // Power set point
    reg  [15:0] exc_limit;   // Exciter power limit
    reg  [15:0] cut_limit;   // Cutback limit
    reg  [6:0]  irq_stat;    // Sticky events
    reg  [6:0]  irq_mask;    // Event mask
    reg  [15:0] accum;       // Cutback accumulator
    reg  [27:0] avg_acc;     // Averaged reflection, 12 fraction bits
    reg  [6:0]  events;      // This cycle's events

    // Shutback when any source trips
    wire calc_trip  = sample_valid && (calc_peak_reflect > `RPP_CALC_LIM); // (R2)
    wire any_trip   = ctrl[`RPP_CTRL_ENABLE] & (calc_trip | (|trips_sync)); // (R3)
    wire new_shut   = any_trip & ~drive_inhibit_hold; // A held trip level counts once

    // ------------------------------------------------------------
    // Shutback sequencer
    // ------------------------------------------------------------
    localparam [3:0] ST_RUN  = 4'b0001;
    localparam [3:0] ST_HOLD = 4'b0010;
    localparam [3:0] ST_RAMP = 4'b0100;
    localparam [3:0] ST_WAIT = 4'b1000;

    reg [3:0]  state;
    reg [15:0] timer_ms;   // Millisecond counter
    reg [15:0] ramp;       // Present ramp output
    reg [15:0] trip_power; // Power limit on the last trip cycle
    reg        cutback_on; // A cutback is in force
    reg [5:0]  decay_cnt;  // Sub-step of accumulator decay

    // Lower of two powers
    function [15:0] rpp_min;
        input [15:0] a;
        input [15:0] b;
        begin
            rpp_min = (a < b) ? a : b;
        end
    endfunction

    // Scale by 85 percent with floor
    function [15:0] rpp_cut;
        input [15:0] p;
        reg   [31:0] prod;
        begin
            prod    = p * `RPP_CUT_NUM;
            rpp_cut = (prod[23:8] < `RPP_FLOOR) ? `RPP_FLOOR : prod[23:8]; // (R12)
        end
    endfunction

    wire [15:0] target = rpp_min(rpp_min(setpoint, exc_limit), cut_limit); // (R5)
    wire [15:0] gap    = target - ramp;
    wire        acc_over = ({1'b0, accum} + {1'b0, `RPP_ACC_ONE}) > {1'b0, ACC_THR};

    // Sequencer, accumulator, cutback limit
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state       <= ST_RUN;
            timer_ms    <= 16'h0;
            ramp        <= 16'h0;
            trip_power  <= 16'h0;
            accum       <= 16'h0;
            decay_cnt   <= 6'h0;
            cut_limit   <= `RPP_FULL;
            cutback_on  <= 1'b0;
            fast_latch  <= 1'b0;
            calc_reflect_trip_alarm <= 1'b0;
            drive_inhibit_hold <= 1'b0;
            events      <= 7'h0;
        end else begin
            events <= 7'h0;
            calc_reflect_trip_alarm <= calc_trip;                   // (R2)
            if (any_trip) begin
                // New shutback, any state
                state       <= ST_HOLD;                              // (R3)
                timer_ms    <= 16'h0;
                ramp        <= 16'h0;                                // (R2)
                trip_power  <= power_limit;
                accum <= new_shut ? `RPP_ACC_ONE + (acc_over ? 16'h0 : accum) : accum; // (R7)
                fast_latch  <= trips_sync[0];
                drive_inhibit_hold <= 1'b1;                          // (R15)
                events[`RPP_EV_CALC] <= calc_trip & new_shut;
                events[4:1] <= trips_sync & {4{new_shut}};
                if (new_shut && acc_over) begin
                    // Cutback declared
                    events[`RPP_EV_CUTBACK] <= 1'b1;                 // (R9)
                    cutback_on <= 1'b1;
                    if (!cutback_on) begin
                        cut_limit <= rpp_cut(rpp_min(setpoint, power_limit)); // (R10)
                    end else begin
                        cut_limit <= rpp_cut(cut_limit);             // (R11)
                    end
                end
            end else begin
                // Accumulator linear decay, 1/60 per second
                if (tick_ms && accum != 16'h0) begin
                    if (decay_cnt == `RPP_DECAY_STEP_MS - 1) begin
                        decay_cnt <= 6'h0;
                        accum     <= accum - 16'h1;                  // (R8)
                    end else begin
                        decay_cnt <= decay_cnt + 6'h1;
                    end
                end
                // Gradual restore after accumulator empty
                if (tick_ms && cutback_on && accum == 16'h0) begin   // (R13)
                    if (cut_limit >= `RPP_FULL - REST_STEP) begin    // (R16)
                        cut_limit  <= `RPP_FULL;
                        cutback_on <= 1'b0;
                    end else begin
                        cut_limit <= cut_limit + REST_STEP;
                    end
                end
                case (state)
                    ST_RUN: begin
                        ramp <= target;
                    end
                    ST_HOLD: begin
                        ramp <= 16'h0;
                        if (tick_ms) begin
                            if (timer_ms == `RPP_HOLD_MS - 1) begin  // (R4)
                                state      <= ST_RAMP;
                                timer_ms   <= 16'h0;
                                fast_latch <= 1'b0;
                                drive_inhibit_hold <= 1'b0;
                            end else begin
                                timer_ms <= timer_ms + 16'h1;
                            end
                        end
                    end
                    ST_RAMP, ST_WAIT: begin
                        // Exponential approach: close 1/64 of gap per ms
                        if (tick_ms) begin
                            ramp <= (gap[15] || gap < 16'h40) ? target :
                                    ramp + {6'h0, gap[15:6]};         // (R5)
                            if (timer_ms == `RPP_RECOV_MS - 1) begin
                                state    <= ST_RUN;                  // (R6)
                                timer_ms <= 16'h0;
                            end else begin
                                timer_ms <= timer_ms + 16'h1;
                            end
                        end
                    end
                    default: begin
                        state <= ST_RUN;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Average reflected power foldback
    // ------------------------------------------------------------
    reg [15:0] fold;    // Foldback limit
    reg [12:0] avg_ms;  // Window counter
    // Single-pole average, time constant about 4 s (4096 ms) in ms steps
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            avg_acc <= 28'h0;
            fold    <= `RPP_FULL;
            avg_ms  <= 13'h0;
        end else if (tick_ms) begin
            avg_acc <= avg_acc - {12'h0, avg_acc[27:12]} + {12'h0, avg_reflect_sample}; // (R14)
            if (avg_ms == `RPP_AVG_MS / 50 - 1) begin
                avg_ms <= 13'h0;
                if (avg_acc[27:12] > `RPP_AVG_LIM && fold > 16'h10) begin
                    fold <= fold - 16'h10;                           // (R14)
                end else if (avg_acc[27:12] < `RPP_AVG_LIM && fold < `RPP_FULL) begin
                    fold <= fold + 16'h10;
                end
            end else begin
                avg_ms <= avg_ms + 13'h1;
            end
        end
    end

    // Limit output, from a register
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            power_limit       <= 16'h0;
            output_level_loop <= 1'b0;
        end else begin
            power_limit       <= any_trip ? 16'h0 : rpp_min(ramp, fold); // (R2)
            output_level_loop <= (state == ST_RUN) && !any_trip;    // (R6)
        end
    end

    // ------------------------------------------------------------
    // AHB-Lite slave, zero wait states
    // ------------------------------------------------------------
    reg        dp_wr;
    reg        dp_rd;
    reg [7:0]  dp_addr;
    reg [31:0] rdata;
    wire       take = hsel & hready & htrans[1];
    wire       rd_stat = dp_rd && dp_addr == `RPP_REG_IRQ_STAT;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_wr   <= 1'b0;
            dp_rd   <= 1'b0;
            dp_addr <= 8'h0;
        end else begin
            dp_wr   <= take & hwrite;
            dp_rd   <= take & ~hwrite;
            dp_addr <= haddr[7:0];
        end
    end

    // Register writes and sticky status; set beats read-clear
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl      <= `RPP_CTRL_RST;
            setpoint  <= `RPP_FULL;
            exc_limit <= `RPP_FULL;
            irq_mask  <= 7'h0;
            irq_stat  <= 7'h0;
        end else begin
            irq_stat <= (rd_stat ? 7'h0 : irq_stat) | events |
                        {fold < `RPP_FULL && !rd_stat && irq_stat[6], 6'h0};
            if (dp_wr) begin
                if (dp_addr == `RPP_REG_CTRL) begin
                    ctrl <= hwdata;
                end else if (dp_addr == `RPP_REG_SETPT) begin
                    setpoint <= hwdata[15:0];
                end else if (dp_addr == `RPP_REG_EXCLIM) begin
                    exc_limit <= hwdata[15:0];
                end else if (dp_addr == `RPP_REG_IRQ_MASK) begin
                    irq_mask <= hwdata[6:0];
                end
            end
        end
    end

    // Read mux; unmapped reads zero
    always @* begin
        if (dp_addr == `RPP_REG_CTRL)           rdata = ctrl;
        else if (dp_addr == `RPP_REG_SETPT)     rdata = {16'h0, setpoint};
        else if (dp_addr == `RPP_REG_EXCLIM)    rdata = {16'h0, exc_limit};
        else if (dp_addr == `RPP_REG_LIMIT)     rdata = {cut_limit, power_limit};
        else if (dp_addr == `RPP_REG_STATUS)    rdata = {24'h0, cutback_on, state,
                                                          drive_inhibit_hold,
                                                          output_level_loop, fast_latch};
        else if (dp_addr == `RPP_REG_IRQ_STAT)  rdata = {25'h0, irq_stat};
        else if (dp_addr == `RPP_REG_IRQ_MASK)  rdata = {25'h0, irq_mask};
        else if (dp_addr == `RPP_REG_ACCUM)     rdata = {16'h0, accum};
        else if (dp_addr == `RPP_REG_REFLECT)   rdata = {fold, avg_acc[27:12]};
        else                                    rdata = 32'h0;
    end

    assign hrdata    = rdata;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign irq       = |(irq_stat & irq_mask);
endmodule

// ### logic/rpp_defines.vh
`ifndef RPP_DEFINES_VH
`define RPP_DEFINES_VH
// ------------------------------------------------------------
// Register offsets (byte addresses)
// ------------------------------------------------------------
`define RPP_REG_CTRL      8'h00
`define RPP_REG_SETPT     8'h04
`define RPP_REG_EXCLIM    8'h08
`define RPP_REG_LIMIT     8'h0c
`define RPP_REG_STATUS    8'h10
`define RPP_REG_IRQ_STAT  8'h14
`define RPP_REG_IRQ_MASK  8'h18
`define RPP_REG_ACCUM     8'h1c
`define RPP_REG_REFLECT   8'h20
// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define RPP_CTRL_ENABLE   0
`define RPP_EV_CALC       0
`define RPP_EV_FAST       1
`define RPP_EV_OVC        2
`define RPP_EV_OVV        3
`define RPP_EV_ARC        4
`define RPP_EV_CUTBACK    5
`define RPP_EV_FOLDBACK   6
// ------------------------------------------------------------
// Reset values and scale (power in 1/4096 of rated)
// ------------------------------------------------------------
`define RPP_FULL          16'h1000
`define RPP_CTRL_RST      32'h00000001
`define RPP_CALC_LIM      16'h028f
`define RPP_AVG_LIM       16'h00a4
`define RPP_FLOOR         16'h0400
`define RPP_CUT_NUM       16'h00d9
`define RPP_ACC_ONE       16'h0f00
`define RPP_ACC_THR       16'h2580
// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define RPP_CLK_MHZ       100
`define RPP_TICK_US       1000
`define RPP_TICK_CYC      (`RPP_CLK_MHZ * `RPP_TICK_US)
`define RPP_HOLD_MS       100
`define RPP_RECOV_MS      30000
`define RPP_DECAY_MS      60000
`define RPP_AVG_MS        5000
`define RPP_DECAY_STEP_MS 16
`endif

// ### logic/rpp_tick.v
`timescale 1ns/1ps
`include "rpp_defines.vh"
// ------------------------------------------------------------
// Millisecond tick prescaler
// ------------------------------------------------------------
module rpp_tick #(
    parameter DIV = `RPP_TICK_CYC
) (
    // Clock and reset
    input  wire        hclk,
    input  wire        hresetn,
    // Tick out
    output reg         tick_ms
);
    reg [31:0] cnt; // Cycle counter

    // Count up one period then pulse
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt     <= 32'h0;
            tick_ms <= 1'b0;
        end else if (cnt == DIV - 1) begin // (R17)
            cnt     <= 32'h0;
            tick_ms <= 1'b1;
        end else begin
            cnt     <= cnt + 32'h1;
            tick_ms <= 1'b0;
        end
    end
endmodule

// ### logic/rpp_sync.v
`timescale 1ns/1ps
// ------------------------------------------------------------
// Three-stage pin synchroniser, change taken when 2nd and 3rd agree
// ------------------------------------------------------------
module rpp_sync #(
    parameter W = 4
) (
    // Clock and reset
    input  wire         hclk,
    input  wire         hresetn,
    // Pins and clean result
    input  wire [W-1:0] pin,
    output reg  [W-1:0] clean
);
    reg [W-1:0] s1; // Metastable stage, read only by s2
    reg [W-1:0] s2;
    reg [W-1:0] s3;
    integer i;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s1    <= {W{1'b0}};
            s2    <= {W{1'b0}};
            s3    <= {W{1'b0}};
            clean <= {W{1'b0}};
        end else begin
            s1 <= pin;
            s2 <= s1;
            s3 <= s2;
            for (i = 0; i < W; i = i + 1) begin
                if (s2[i] == s3[i]) begin
                    clean[i] <= s3[i];
                end
            end
        end
    end
endmodule

// ### testbench/rpp_pa_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Power stage model: reflected power follows the commanded level
// ------------------------------------------------------------
module rpp_pa_model (
    // Clock
    input  wire        hclk,
    // Commands from the block
    input  wire [15:0] power_limit,
    input  wire        drive_disable,
    // Bench fault control
    input  wire        load_fault,
    // Reflected power samples
    output reg  [15:0] calc_peak_reflect,
    output reg  [15:0] avg_reflect_sample,
    output reg         sample_valid
);
    initial begin
        calc_peak_reflect = 16'h0000;
        avg_reflect_sample = 16'h0000;
        sample_valid = 1'b0;
    end
    // A bad load sends all power back; a good one about 1.5 percent
    always @(posedge hclk) begin
        sample_valid <= 1'b1;
        if (drive_disable) begin
            // No RF out, nothing comes back
            calc_peak_reflect <= 16'h0000;
            avg_reflect_sample <= 16'h0000;
        end else begin
            calc_peak_reflect <= load_fault ? power_limit : (power_limit >> 6);
            avg_reflect_sample <= power_limit >> 6;
        end
    end
endmodule

// ### testbench/rpp_top_asserts.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Protection checker, ports of the top only
// ------------------------------------------------------------
module rpp_top_asserts #(
    parameter TICK_DIV = 100000
) (
    // Clock and reset
    input wire        hclk,
    input wire        hresetn,
    // Samples and trips
    input wire [15:0] calc_peak_reflect,
    input wire        sample_valid,
    input wire [3:0]  trip_pins,
    // Power stage
    input wire        fast_reflect_trip_alarm,
    input wire        calc_reflect_trip_alarm,
    input wire        drive_disable,
    input wire        modulation_zero,
    input wire        drive_inhibit_hold,
    input wire [15:0] power_limit,
    input wire        output_level_loop
);
    // Hold may start mid tick, so one tick of slack
    localparam HOLD_MIN = 99 * TICK_DIV;
    reg [31:0] hold_cnt; // Cycles of the current hold
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hold_cnt <= 32'h0;
        end else if (drive_inhibit_hold) begin
            hold_cnt <= hold_cnt + 32'h1;
        end else begin
            hold_cnt <= 32'h0;
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_fast_kill_now: assert property (trip_pins[0] |-> fast_reflect_trip_alarm &&
        drive_disable && modulation_zero) else $error("fast trip not immediate");
    a_calc_alarm_next: assert property (sample_valid && calc_peak_reflect > 16'h028f
        |=> calc_reflect_trip_alarm) else $error("calc alarm missing");
    a_calc_zero_power: assert property (sample_valid && calc_peak_reflect > 16'h028f
        |=> power_limit == 16'h0000) else $error("calc trip kept power");
    a_pin_shutback: assert property ($rose(|trip_pins) |-> ##[1:6]
        (drive_inhibit_hold && power_limit == 16'h0000)) else $error("pin trip no shutback");
    a_hold_zero: assert property (drive_inhibit_hold && $past(drive_inhibit_hold)
        |-> power_limit == 16'h0000) else $error("power during hold");
    a_hold_length: assert property ($fell(drive_inhibit_hold) |-> hold_cnt >= HOLD_MIN)
        else $error("hold too short");
    a_ramp_start: assert property ($fell(drive_inhibit_hold) |-> ##[1:1000]
        power_limit != 16'h0000) else $error("no ramp after hold");
    a_power_ceiling: assert property (power_limit <= 16'h1000)
        else $error("power above full");
    a_loop_idle: assert property (drive_inhibit_hold |-> !output_level_loop)
        else $error("loop active during hold");
    a_inhibit_drive: assert property (drive_inhibit_hold |-> drive_disable)
        else $error("inhibit without disable");
    c_fast: cover property ($rose(fast_reflect_trip_alarm));
    c_calc: cover property ($rose(calc_reflect_trip_alarm));
    c_hold_end: cover property ($fell(drive_inhibit_hold));
endmodule
bind rpp_top rpp_top_asserts #(.TICK_DIV(TICK_DIV)) u_chk (.hclk, .hresetn,
    .calc_peak_reflect, .sample_valid, .trip_pins, .fast_reflect_trip_alarm,
    .calc_reflect_trip_alarm, .drive_disable, .modulation_zero, .drive_inhibit_hold,
    .power_limit, .output_level_loop);

// ### testbench/reflected_power_protection_tb.sv
`timescale 1ns/1ps
`include "rpp_defines.vh"
module reflected_power_protection_tb;
    // Short prescale keeps the 100 ms hold at 1000 cycles
    localparam DIV = 10;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    reg         hclk = 1'b0;
    reg         hresetn = 1'b0;
    reg         hsel = 1'b1;
    reg  [31:0] haddr = 32'h0;
    reg  [1:0]  htrans = 2'b00;
    reg         hwrite = 1'b0;
    reg  [31:0] hwdata = 32'h0;
    reg  [3:0]  trip_pins = 4'h0;
    reg         load_fault = 1'b0;
    wire [31:0] hrdata;
    wire        hreadyout, irq, drive_disable, drive_inhibit_hold, sample_valid;
    wire [15:0] power_limit, calc_peak_reflect, avg_reflect_sample;
    integer     n_errors = 0;
    integer     samples_checked = 0;
    reg  [63:0] exp_q[$]; // Expected read data and mask
    reg  [63:0] note;
    reg         rd_ph = 1'b0; // Read data phase in flight
    reg  [15:0] setpt, cut, target;
    reg         cb;                // This trip should cut back
    reg  [31:0] tmp;
    integer     i, n, src;
    always #5 hclk = ~hclk;
    rpp_top #(.TICK_DIV(DIV)) u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(),
        .calc_peak_reflect(calc_peak_reflect), .avg_reflect_sample(avg_reflect_sample),
        .sample_valid(sample_valid), .trip_pins(trip_pins), .fast_reflect_trip_alarm(),
        .calc_reflect_trip_alarm(), .drive_disable(drive_disable), .modulation_zero(),
        .drive_inhibit_hold(drive_inhibit_hold), .power_limit(power_limit),
        .output_level_loop(), .irq(irq));
    rpp_pa_model u_pa (.hclk(hclk), .power_limit(power_limit), .drive_disable(drive_disable),
        .load_fault(load_fault), .calc_peak_reflect(calc_peak_reflect),
        .avg_reflect_sample(avg_reflect_sample), .sample_valid(sample_valid));
    // ------------------------------------------------------------
    // Compare tasks and closing
    // ------------------------------------------------------------
    task cmp_word(input [31:0] got, input [31:0] exp, input [31:0] msk);
        samples_checked = samples_checked + 1;
        if ((got & msk) !== (exp & msk)) begin
            n_errors = n_errors + 1;
            $display("CHECK FAILED at %0t: read %h expected %h", $time, got, exp);
        end
    endtask
    task cmp_bit(input got, input exp);
        samples_checked = samples_checked + 1;
        if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("CHECK FAILED at %0t: flag %b expected %b", $time, got, exp);
        end
    endtask
    task tally_and_finish;
        if (n_errors == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // Bus master: hold each phase until hready is seen high
    // ------------------------------------------------------------
    task bus_phase(input [31:0] a, input w, input [31:0] d);
        @(posedge hclk);
        haddr <= a;
        hwrite <= w;
        htrans <= 2'b10;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
    endtask
    task ahb_read(input [31:0] a, input [31:0] e, input [31:0] m);
        exp_q.push_back({e, m});
        bus_phase(a, 1'b0, 32'h0);
    endtask
    // Monitor: read data is taken at the edge closing the data phase
    always @(posedge hclk) begin
        if (rd_ph && exp_q.size() > 0) begin
            note = exp_q.pop_front();
            cmp_word(hrdata, note[63:32], note[31:0]);
        end
        rd_ph <= hsel && hreadyout && htrans[1] && !hwrite;
    end
    // Exponential ramp may approach slowly, so a wide bound
    task wait_power(input [15:0] t);
        n = 0;
        while (power_limit !== t && n < 20000) begin
            @(posedge hclk);
            n = n + 1;
        end
        cmp_bit(power_limit === t, 1'b1);
    endtask
    // Watchdog
    initial begin
        #1000000;
        n_errors = n_errors + 1;
        tally_and_finish;
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(20587));
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        ahb_read(`RPP_REG_CTRL, `RPP_CTRL_RST, 32'hffffffff);
        ahb_read(32'h40, 32'h0, 32'hffffffff);
        setpt = 16'h0800 + ($urandom % 256);
        bus_phase(`RPP_REG_SETPT, 1'b1, {16'h0, setpt});
        ahb_read(`RPP_REG_SETPT, {16'h0, setpt}, 32'h0000ffff);
        bus_phase(`RPP_REG_IRQ_MASK, 1'b1, 32'h0);
        cut = 16'h1000;
        wait_power(setpt);
        // Twelve trips over all five sources; every second from the third cuts back
        for (i = 0; i < 12; i = i + 1) begin
            src = i % 5;
            @(posedge hclk);
            if (src == 0) load_fault <= 1'b1;
            else trip_pins[src-1] <= 1'b1;
            repeat (8) @(posedge hclk);
            load_fault <= 1'b0;
            trip_pins <= 4'h0;
            n = 0;
            while (drive_inhibit_hold !== 1'b0 && n < 3000) begin
                @(posedge hclk);
                n = n + 1;
            end
            cmp_bit(drive_inhibit_hold, 1'b0);
            cb = (i >= 2) && (i % 2 == 0); // Accumulator restarts at one after a cutback
            tmp = ((i == 2) ? setpt : cut) * 217;
            if (cb) cut = (tmp[23:8] < 16'h0400) ? 16'h0400 : tmp[23:8];
            target = (cut < setpt) ? cut : setpt;
            wait_power(target);
            if (i == 0) begin
                cmp_bit(irq, 1'b0);
                bus_phase(`RPP_REG_IRQ_MASK, 1'b1, 32'h7f);
                @(posedge hclk);
            end
            cmp_bit(irq, 1'b1);
            ahb_read(`RPP_REG_IRQ_STAT, (32'h1 << src) | (cb ? 32'h20 : 32'h0), 32'h3f);
            ahb_read(`RPP_REG_LIMIT, {cut, target}, 32'hffffffff);
            #1;
            cmp_bit(irq, 1'b0);
        end
        tally_and_finish;
    end
endmodule
